// ===== hdl/atm_pkg.sv
// Constants and types of the trace and limit analyser
//
// Functional notes
// - Status bits 7:4 echo limit request bits
// - Active, limit-enabled channel tracks running min and max
// - New period shows previous extremes, restarts tracking
// - Extremes signed 16-bit, zero when channel inactive
// - Per-channel 16-bit count of period starts
// - Record only channels selected in select byte
// - Storage split equally among selected channels
// - Depth 2 to 8192, total at most 8192
// - Priority 3 standard, 6 favours trace
// - Arm bit 0 enables trace, 0 disables
// - Trace state byte holds seven status flags
// - Free trace space reported in bytes
// - Count triggers taken since trace start
// - Count triggers that could not trace
// - On trigger stream buffered samples out
// - Within-limits bit set inside thresholds
// - Threshold bit set above upper, cleared below
// - Status word: current low, previous high
// - Masked XOR compare with AND/OR terms
`default_nettype none
package atm_pkg;
  localparam logic [5:0] A_CTL = 6'h00, A_FALL = 6'h01, A_RISE = 6'h02, A_ECHO = 6'h03;
  localparam logic [5:0] A_MIN = 6'h04, A_MAX = 6'h08, A_CNT = 6'h0C, A_SEL = 6'h10;
  localparam logic [5:0] A_DEPTH = 6'h11, A_PRIO = 6'h12, A_ARM = 6'h13, A_STATE = 6'h14;
  localparam logic [5:0] A_FREE = 6'h15, A_TOTAL = 6'h16, A_FAIL = 6'h17, A_LOW = 6'h18;
  localparam logic [5:0] A_HIGH = 6'h1C, A_COLL = 6'h20, A_TARGET = 6'h21, A_MASK = 6'h22;
  localparam logic [5:0] A_OPER = 6'h23, A_CHCFG = 6'h24;
  localparam int         BUF_WORDS    = 8192;
  localparam logic [15:0] DEPTH_MIN   = 16'h0002;
  localparam logic [15:0] DEPTH_MAX   = 16'h2000;
  localparam logic [15:0] CAP_4       = 16'h0800;
  localparam logic [15:0] CAP_3       = 16'h0AAA;
  localparam logic [15:0] CAP_2       = 16'h1000;
  localparam logic [15:0] DEPTH_RST   = 16'h2000;
  localparam logic [7:0]  PRIO_RST    = 8'h03;
  localparam logic [7:0]  PRIO_HIGH   = 8'h06;
  localparam logic [15:0] S16_MAX     = 16'h7FFF;
  localparam logic [15:0] S16_MIN     = 16'h8000;
  localparam int          B_ACTIVE = 0, B_WRITE = 2, B_READ = 3, B_READY = 4;
  localparam int          B_PEND = 5, B_OK = 6, B_FULL = 7;
  localparam int          B_TRACE = 0, B_LIM0 = 4;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_ARMED = 3'b010,
    ST_READ  = 3'b100
  } atm_state_e;
endpackage
`default_nettype wire

// ===== hdl/atm_analyzer.sv
// Min/max tracking, trace recorder and hysteresis trigger comparator
`default_nettype none
module atm_analyzer (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [5:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        sample_valid,
  input  wire logic [63:0] sample_data,
  output logic             rec_valid,
  output logic      [15:0] rec_data,
  input  wire logic        rec_ready
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [2:0] ones(input logic [3:0] v);
    ones = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
  endfunction
  function automatic logic [15:0] ch_cap(input logic [2:0] n);
    unique case (n)
      3'd4:    ch_cap = atm_pkg::CAP_4;
      3'd3:    ch_cap = atm_pkg::CAP_3;
      3'd2:    ch_cap = atm_pkg::CAP_2;
      default: ch_cap = atm_pkg::DEPTH_MAX;
    endcase
  endfunction
  function automatic logic [15:0] smp(input logic [63:0] d, input int i);
    smp = d[16*i +: 16];
  endfunction

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [7:0]  ctl_r, ctl_prev_r, fall_r, rise_r, sel_r, prio_r, arm_r, chcfg_r;
  logic [15:0] depth_r, target_r, mask_r, oper_r, coll_r, total_r, fail_r;
  logic [15:0] low_r [4];
  logic [15:0] high_r [4];
  logic [15:0] trk_min_r [4];
  logic [15:0] trk_max_r [4];
  logic [15:0] min_r [4];
  logic [15:0] max_r [4];
  logic [15:0] cnt_r [4];
  logic [15:0] limit_r, count_r, wptr_r, rptr_r;
  logic [3:0]  thr_r, pend_r;
  logic [63:0] hold_r;
  logic        ovf_r, pend_trig_r, pace_r, hit_prev_r;
  atm_pkg::atm_state_e st_r;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctl_r   <= 8'h00;
      fall_r  <= 8'h00;
      rise_r  <= 8'h00;
      sel_r   <= 8'h00;
      prio_r  <= atm_pkg::PRIO_RST;
      arm_r   <= 8'h00;
      chcfg_r <= 8'h00;
      depth_r <= atm_pkg::DEPTH_RST;
      target_r <= 16'h0000;
      mask_r  <= 16'h0000;
      oper_r  <= 16'h0000;
      for (int i = 0; i < 4; i++) begin
        low_r[i]  <= 16'h0000;
        high_r[i] <= 16'h0000;
      end
    end else if (reg_wr) begin
      unique case (reg_addr)
        atm_pkg::A_CTL:    ctl_r   <= reg_wdata[7:0];
        atm_pkg::A_FALL:   fall_r  <= reg_wdata[7:0] & 8'hF1;
        atm_pkg::A_RISE:   rise_r  <= reg_wdata[7:0] & 8'hF1;
        atm_pkg::A_SEL:    sel_r   <= reg_wdata[7:0] & 8'h0F;
        atm_pkg::A_DEPTH:  depth_r <= reg_wdata;
        atm_pkg::A_PRIO:   prio_r  <= reg_wdata[7:0];
        atm_pkg::A_ARM:    arm_r   <= reg_wdata[7:0] & 8'h01;
        atm_pkg::A_CHCFG:  chcfg_r <= reg_wdata[7:0];
        atm_pkg::A_TARGET: target_r <= reg_wdata;
        atm_pkg::A_MASK:   mask_r  <= reg_wdata;
        atm_pkg::A_OPER:   oper_r  <= reg_wdata;
        default: begin
          if (reg_addr[5:2] == atm_pkg::A_LOW[5:2]) begin
            low_r[reg_addr[1:0]] <= reg_wdata;
          end else if (reg_addr[5:2] == atm_pkg::A_HIGH[5:2]) begin
            high_r[reg_addr[1:0]] <= reg_wdata;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Control byte edge detection
  // ----------------------------------------
  logic [7:0] ctl_evt;
  logic [3:0] per_evt, active, lim_en;
  assign ctl_evt = (ctl_r & ~ctl_prev_r & rise_r) | (~ctl_r & ctl_prev_r & fall_r);
  assign per_evt = ctl_evt[7:4];
  assign active  = chcfg_r[3:0];
  assign lim_en  = chcfg_r[7:4];

  // ----------------------------------------
  // Limit value analysis
  // ----------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 4; i++) begin
        trk_min_r[i] <= atm_pkg::S16_MAX;
        trk_max_r[i] <= atm_pkg::S16_MIN;
        min_r[i]     <= 16'h0000;
        max_r[i]     <= 16'h0000;
        cnt_r[i]     <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (per_evt[i]) begin
          min_r[i] <= trk_min_r[i];
          max_r[i] <= trk_max_r[i];
          cnt_r[i] <= cnt_r[i] + 16'h0001;
          // Restart seeds from the coincident sample so it is not lost
          trk_min_r[i] <= (sample_valid && lim_en[i]) ? smp(sample_data, i) : atm_pkg::S16_MAX;
          trk_max_r[i] <= (sample_valid && lim_en[i]) ? smp(sample_data, i) : atm_pkg::S16_MIN;
        end else if (sample_valid && lim_en[i] && active[i]) begin
          if ($signed(smp(sample_data, i)) < $signed(trk_min_r[i])) begin
            trk_min_r[i] <= smp(sample_data, i);
          end
          if ($signed(smp(sample_data, i)) > $signed(trk_max_r[i])) begin
            trk_max_r[i] <= smp(sample_data, i);
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Hysteresis comparator
  // ----------------------------------------
  logic [7:0] cur_bits;
  logic [15:0] cond;
  logic        hit;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cur_bits[2*i] = thr_r[i];
      if ($signed(smp(sample_data, i)) > $signed(high_r[i])) begin
        cur_bits[2*i] = 1'b1;
      end else if ($signed(smp(sample_data, i)) < $signed(low_r[i])) begin
        cur_bits[2*i] = 1'b0;
      end
      cur_bits[2*i+1] = ($signed(smp(sample_data, i)) >= $signed(low_r[i])) &&
                        ($signed(smp(sample_data, i)) <= $signed(high_r[i]));
      if (!active[i]) begin
        cur_bits[2*i]   = 1'b0;
        cur_bits[2*i+1] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      coll_r <= 16'h0000;
      thr_r  <= 4'h0;
    end else if (sample_valid) begin
      coll_r <= {coll_r[7:0], cur_bits};
      for (int i = 0; i < 4; i++) begin
        thr_r[i] <= cur_bits[2*i];
      end
    end
  end

  // Without an OR term the comparator trigger can never fire
  assign cond = (coll_r ^ target_r) & mask_r;
  assign hit  = ((cond & ~oper_r) == 16'h0000) && ((~cond & oper_r) != 16'h0000);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hit_prev_r <= 1'b0;
      ctl_prev_r <= 8'h00;
    end else begin
      hit_prev_r <= hit;
      ctl_prev_r <= ctl_r;
    end
  end

  // ----------------------------------------
  // Trace recorder
  // ----------------------------------------
  logic [15:0] eff_depth, limit_nxt, wptr_inc, rptr_inc;
  logic        trig, take, do_wr, do_rd, rd_done;
  logic [1:0]  wch;
  logic [15:0] mem_r [atm_pkg::BUF_WORDS];

  always_comb begin
    eff_depth = depth_r;
    if (eff_depth < atm_pkg::DEPTH_MIN) begin
      eff_depth = atm_pkg::DEPTH_MIN;
    end
    if (eff_depth > ch_cap(ones(sel_r[3:0]))) begin
      eff_depth = ch_cap(ones(sel_r[3:0]));
    end
    limit_nxt = 16'(eff_depth * 16'(ones(sel_r[3:0])));
    wch = 2'd0;
    for (int i = 3; i >= 0; i--) begin
      if (pend_r[i]) begin
        wch = 2'(i);
      end
    end
  end

  assign trig     = ctl_evt[atm_pkg::B_TRACE] | (hit & ~hit_prev_r);
  assign take     = trig && (st_r == atm_pkg::ST_ARMED) && (count_r != 16'h0000);
  assign do_wr    = (st_r == atm_pkg::ST_ARMED) && (pend_r != 4'h0);
  // Standard priority streams every other cycle, high priority every cycle
  assign do_rd    = (st_r == atm_pkg::ST_READ) && (count_r != 16'h0000) && (!rec_valid || rec_ready) &&
                    (pace_r || prio_r == atm_pkg::PRIO_HIGH);
  assign rd_done  = (st_r == atm_pkg::ST_READ) && (count_r == 16'h0000) && (!rec_valid || rec_ready);
  assign wptr_inc = (wptr_r + 16'h0001 >= limit_r) ? 16'h0000 : wptr_r + 16'h0001;
  assign rptr_inc = (rptr_r + 16'h0001 >= limit_r) ? 16'h0000 : rptr_r + 16'h0001;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= atm_pkg::ST_IDLE;
    end else if (!arm_r[0]) begin
      st_r <= atm_pkg::ST_IDLE;
    end else begin
      unique case (st_r)
        atm_pkg::ST_IDLE:  st_r <= atm_pkg::ST_ARMED;
        atm_pkg::ST_ARMED: st_r <= take ? atm_pkg::ST_READ : atm_pkg::ST_ARMED;
        atm_pkg::ST_READ:  st_r <= rd_done ? atm_pkg::ST_ARMED : atm_pkg::ST_READ;
        default:           st_r <= atm_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      total_r     <= 16'h0000;
      fail_r      <= 16'h0000;
      pend_trig_r <= 1'b0;
    end else begin
      if (st_r == atm_pkg::ST_IDLE && arm_r[0]) begin
        total_r <= 16'h0000;
      end else if (take) begin
        total_r <= total_r + 16'h0001;
      end
      if (trig && arm_r[0] && !take) begin
        fail_r <= fail_r + 16'h0001;
      end
      pend_trig_r <= take | (pend_trig_r & ~rd_done & arm_r[0]);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      limit_r <= 16'h0000;
      count_r <= 16'h0000;
      wptr_r  <= 16'h0000;
      rptr_r  <= 16'h0000;
      pend_r  <= 4'h0;
      hold_r  <= 64'h0;
      ovf_r   <= 1'b0;
    end else if (st_r == atm_pkg::ST_IDLE) begin
      limit_r <= limit_nxt;
      count_r <= 16'h0000;
      wptr_r  <= 16'h0000;
      rptr_r  <= 16'h0000;
      pend_r  <= 4'h0;
      ovf_r   <= 1'b0;
    end else begin
      if (sample_valid && st_r == atm_pkg::ST_ARMED) begin
        if (pend_r != 4'h0) begin
          ovf_r <= 1'b1;
        end
        pend_r <= sel_r[3:0];
        hold_r <= sample_data;
      end else if (do_wr) begin
        pend_r[wch] <= 1'b0;
      end
      if (sample_valid && st_r == atm_pkg::ST_READ && sel_r[3:0] != 4'h0) begin
        ovf_r <= 1'b1;
      end
      if (do_wr) begin
        wptr_r <= wptr_inc;
        if (count_r == limit_r) begin
          rptr_r <= rptr_inc; // Oldest word overwritten
        end else begin
          count_r <= count_r + 16'h0001;
        end
      end else if (do_rd) begin
        rptr_r  <= rptr_inc;
        count_r <= count_r - 16'h0001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (do_wr) begin
      mem_r[wptr_r[12:0]] <= smp(hold_r, int'(wch));
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rec_valid <= 1'b0;
      rec_data  <= 16'h0000;
      pace_r    <= 1'b0;
    end else begin
      pace_r <= ~pace_r;
      if (do_rd) begin
        rec_valid <= 1'b1;
        rec_data  <= mem_r[rptr_r[12:0]];
      end else if (rec_ready || st_r != atm_pkg::ST_READ) begin
        rec_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [7:0]  state_byte;
  logic [15:0] free_bytes;
  assign state_byte = {(arm_r[0] && limit_r != 16'h0000 && count_r == limit_r),
                       (arm_r[0] && !ovf_r), pend_trig_r, (st_r == atm_pkg::ST_ARMED),
                       (st_r == atm_pkg::ST_READ), do_wr, 1'b0, arm_r[0]};
  assign free_bytes = 16'((limit_r - count_r) << 1);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        atm_pkg::A_CTL:    reg_rdata <= {8'h00, ctl_r};
        atm_pkg::A_FALL:   reg_rdata <= {8'h00, fall_r};
        atm_pkg::A_RISE:   reg_rdata <= {8'h00, rise_r};
        atm_pkg::A_ECHO:   reg_rdata <= {8'h00, ctl_r[7:4], 4'h0};
        atm_pkg::A_SEL:    reg_rdata <= {8'h00, sel_r};
        atm_pkg::A_DEPTH:  reg_rdata <= depth_r;
        atm_pkg::A_PRIO:   reg_rdata <= {8'h00, prio_r};
        atm_pkg::A_ARM:    reg_rdata <= {8'h00, arm_r};
        atm_pkg::A_STATE:  reg_rdata <= {8'h00, state_byte};
        atm_pkg::A_FREE:   reg_rdata <= free_bytes;
        atm_pkg::A_TOTAL:  reg_rdata <= total_r;
        atm_pkg::A_FAIL:   reg_rdata <= fail_r;
        atm_pkg::A_COLL:   reg_rdata <= coll_r;
        atm_pkg::A_TARGET: reg_rdata <= target_r;
        atm_pkg::A_MASK:   reg_rdata <= mask_r;
        atm_pkg::A_OPER:   reg_rdata <= oper_r;
        atm_pkg::A_CHCFG:  reg_rdata <= {8'h00, chcfg_r};
        default: begin
          unique case (reg_addr[5:2])
            atm_pkg::A_MIN[5:2]:  reg_rdata <= active[reg_addr[1:0]] ? min_r[reg_addr[1:0]] : 16'h0000;
            atm_pkg::A_MAX[5:2]:  reg_rdata <= active[reg_addr[1:0]] ? max_r[reg_addr[1:0]] : 16'h0000;
            atm_pkg::A_CNT[5:2]:  reg_rdata <= cnt_r[reg_addr[1:0]];
            atm_pkg::A_LOW[5:2]:  reg_rdata <= low_r[reg_addr[1:0]];
            atm_pkg::A_HIGH[5:2]: reg_rdata <= high_r[reg_addr[1:0]];
            default:              reg_rdata <= 16'h0000;
          endcase
        end
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  echo_bits_a: assert property (reg_rd && reg_addr == atm_pkg::A_ECHO |->
    ##1 reg_rdata == {8'h00, $past(ctl_r[7:4]), 4'h0}) else $error("echo byte wrong");
  edge_only_a: assert property (ctl_evt[4] |->
    (ctl_r[4] && rise_r[4]) || (!ctl_r[4] && fall_r[4])) else $error("period start on unselected edge");
  min_track_a: assert property (sample_valid && lim_en[0] && active[0] && !per_evt[0] &&
    $signed(sample_data[15:0]) < $signed(trk_min_r[0]) |=> trk_min_r[0] == $past(sample_data[15:0]))
    else $error("minimum not tracked");
  period_latch_a: assert property (per_evt[1] |=> min_r[1] == $past(trk_min_r[1]) &&
    max_r[1] == $past(trk_max_r[1])) else $error("period extremes not presented");
  inactive_zero_a: assert property (reg_rd && reg_addr == atm_pkg::A_MAX && !active[0] |=>
    reg_rdata == 16'h0000) else $error("inactive channel not zero");
  evt_count_a: assert property (per_evt[2] |=> cnt_r[2] == $past(cnt_r[2]) + 16'h0001)
    else $error("period counter missed");
  limit_cap_a: assert property (limit_r <= atm_pkg::DEPTH_MAX && count_r <= limit_r)
    else $error("trace storage over limit");
  thr_set_a: assert property (sample_valid && active[0] &&
    $signed(sample_data[15:0]) > $signed(high_r[0]) |=> thr_r[0] && coll_r[0]) else $error("threshold bit not set");
  thr_hold_a: assert property (sample_valid && active[3] &&
    $signed(sample_data[63:48]) >= $signed(low_r[3]) && $signed(sample_data[63:48]) <= $signed(high_r[3])
    |=> thr_r[3] == $past(thr_r[3]) && coll_r[7]) else $error("hysteresis not held");
  arm_off_a: assert property (!arm_r[0] |=> st_r == atm_pkg::ST_IDLE) else $error("trace runs unarmed");
  sequence s_taken;
    take ##1 st_r == atm_pkg::ST_READ;
  endsequence
  trig_count_a: assert property (take |-> s_taken and ##1 total_r == $past(total_r) + 16'h0001)
    else $error("trigger not taken or counted");
  fail_count_a: assert property (trig && arm_r[0] && (st_r == atm_pkg::ST_READ || count_r == 16'h0000)
    |=> fail_r == $past(fail_r) + 16'h0001) else $error("failed trigger not counted");
endmodule
`default_nettype wire

// ===== verification/atm_sink.sv
// Trace stream consumer model, prompt or stalling
`default_nettype none
module atm_sink (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        rec_valid,
  input  wire logic [15:0] rec_data,
  input  wire logic        slow,
  output logic             rec_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] got [$];
  // Random stalls in slow mode force the producer to hold each stalled word
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rec_ready <= 1'b0;
    end else begin
      if (rec_valid && rec_ready) begin
        got.push_back(rec_data);
      end
      rec_ready <= slow ? 1'($urandom_range(1, 0)) : 1'b1;
    end
  end
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the trace and limit analyser
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] LO = 16'hE0C0;
  localparam logic [15:0] HI = 16'h1F40;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic [5:0]  reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic        sample_valid = 1'b0;
  logic [63:0] sample_data = 64'h0;
  logic        rec_valid;
  logic [15:0] rec_data;
  logic        rec_ready;
  logic        slow = 1'b0;
  logic        rec = 1'b0;
  int          err_total = 0;
  int          compares = 0;
  int          mn [4];
  int          mx [4];
  logic        hy [4];
  logic [15:0] coll_w = 16'h0000;
  logic [15:0] words [$];
  int          i;

  always #10 clock = ~clock;

  atm_analyzer i_atm_analyzer (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
    .sample_data(sample_data), .rec_valid(rec_valid), .rec_data(rec_data), .rec_ready(rec_ready));
  atm_sink i_atm_sink (.clock(clock), .reset_n(reset_n), .rec_valid(rec_valid), .rec_data(rec_data),
    .slow(slow), .rec_ready(rec_ready));

  // ----------------------------------------
  // Bus, sample and compare tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] exp, input string what);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask
  // Model of extremes, hysteresis and recording for one sample set
  task automatic smp(input logic [63:0] d);
    int v;
    logic [7:0] nb;
    @(posedge clock);
    sample_valid <= 1'b1;
    sample_data <= d;
    @(posedge clock);
    sample_valid <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      v = $signed(d[16*c +: 16]);
      if (v < mn[c]) mn[c] = v;
      if (v > mx[c]) mx[c] = v;
      if (v > $signed(HI)) hy[c] = 1'b1;
      else if (v < $signed(LO)) hy[c] = 1'b0;
      nb[2*c] = hy[c];
      nb[2*c+1] = (v >= $signed(LO)) && (v <= $signed(HI));
      if (rec && c < 2) words.push_back(d[16*c +: 16]);
    end
    coll_w = {coll_w[7:0], nb};
    repeat (4) @(posedge clock);
  endtask
  task automatic end_of_test();
    $display("Counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(77508));
    for (int c = 0; c < 4; c++) begin
      mn[c] = 32767;
      mx[c] = -32768;
      hy[c] = 1'b0;
    end
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    rd(atm_pkg::A_DEPTH, atm_pkg::DEPTH_RST, "depth");
    rd(atm_pkg::A_PRIO, 16'h0003, "priority");
    rd(atm_pkg::A_STATE, 16'h0000, "state idle");
    rd(6'h3F, 16'h0000, "unmapped");
    $display("Test reset values done");
    wr(atm_pkg::A_CHCFG, 16'h00FF);
    wr(atm_pkg::A_RISE, 16'h00F1);
    for (int c = 0; c < 4; c++) begin
      wr(atm_pkg::A_LOW + 6'(c), LO);
      wr(atm_pkg::A_HIGH + 6'(c), HI);
    end
    for (int p = 0; p < 2; p++) begin
      repeat (6) begin
        smp({$urandom, $urandom});
        rd(atm_pkg::A_COLL, coll_w, "collection");
      end
      wr(atm_pkg::A_CTL, 16'h00F0);
      repeat (3) @(posedge clock);
      rd(atm_pkg::A_ECHO, 16'h00F0, "echo");
      for (int c = 0; c < 4; c++) begin
        rd(atm_pkg::A_MIN + 6'(c), 16'(mn[c]), "period min");
        rd(atm_pkg::A_MAX + 6'(c), 16'(mx[c]), "period max");
        rd(atm_pkg::A_CNT + 6'(c), 16'(p + 1), "period count");
        mn[c] = 32767;
        mx[c] = -32768;
      end
      wr(atm_pkg::A_CTL, 16'h0000);
    end
    // Inactive channel 0 must read a zero maximum
    wr(atm_pkg::A_CHCFG, 16'h00F0);
    rd(atm_pkg::A_MAX, 16'h0000, "inactive max");
    wr(atm_pkg::A_CHCFG, 16'h00FF);
    $display("Test limit periods and comparator done");
    wr(atm_pkg::A_SEL, 16'h0003);
    wr(atm_pkg::A_DEPTH, 16'h0004);
    for (int r = 0; r < 2; r++) begin
      wr(atm_pkg::A_ARM, 16'h0000);
      wr(atm_pkg::A_PRIO, r ? 16'h0003 : 16'h0006);
      slow <= (r == 1);
      wr(atm_pkg::A_ARM, 16'h0001);
      repeat (2) @(posedge clock);
      rd(atm_pkg::A_STATE, 16'h0051, "state armed");
      rec = 1'b1;
      repeat (3) smp({$urandom, $urandom});
      rec = 1'b0;
      rd(atm_pkg::A_FREE, 16'h0004, "free bytes");
      wr(atm_pkg::A_CTL, 16'h0001);
      i = 0;
      while (i_atm_sink.got.size() < 6 && i < 400) begin
        @(posedge clock);
        i++;
      end
      if (i == 400) begin
        err_total++;
        $display("[ERR] trace drain expected 6 seen %0d", i_atm_sink.got.size());
        end_of_test();
      end
      while (words.size() > 0) begin
        chk("trace word", words.pop_front(), i_atm_sink.got.pop_front());
      end
      repeat (4) @(posedge clock);
      rd(atm_pkg::A_TOTAL, 16'h0001, "trigger total");
      rd(atm_pkg::A_STATE, 16'h0051, "state drained");
      wr(atm_pkg::A_CTL, 16'h0000);
      wr(atm_pkg::A_CTL, 16'h0001);
      repeat (3) @(posedge clock);
      rd(atm_pkg::A_FAIL, 16'(r + 1), "trigger failures");
      wr(atm_pkg::A_CTL, 16'h0000);
      $display("Test trace round %0d done", r);
    end
    // Falling edge only counts where its mask bit is set
    wr(atm_pkg::A_FALL, 16'h0010);
    wr(atm_pkg::A_CTL, 16'h0010);
    wr(atm_pkg::A_CTL, 16'h0000);
    repeat (3) @(posedge clock);
    rd(atm_pkg::A_CNT, 16'h0004, "falling edge count");
    rd(atm_pkg::A_CNT + 6'h01, 16'h0002, "unselected count");
    // Empty buffer, so a comparator trigger can only fail
    wr(atm_pkg::A_SEL, 16'h0000);
    wr(atm_pkg::A_TARGET, 16'h0002);
    wr(atm_pkg::A_MASK, 16'h0002);
    smp(64'h0000_0000_0000_7FFF);
    wr(atm_pkg::A_OPER, 16'h0002);
    rd(atm_pkg::A_FAIL, 16'h0002, "no comparator trigger");
    smp(64'h0000_0000_0000_0000);
    rd(atm_pkg::A_COLL, coll_w, "comparator collection");
    rd(atm_pkg::A_FAIL, 16'h0003, "comparator trigger");
    $display("Test edges and comparator done");
    end_of_test();
  end
endmodule
`default_nettype wire
